// file: core/rbt_cfg.svh
/*
 * Constants of the registered bus transceiver: register offsets, field
 * positions, reset values, scan opcodes and synchroniser depth.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH
`define RBT_CLK_PERIOD_NS 10
`define RBT_SYNC_STAGES 2
`define RBT_BUS_W 8
`define RBT_FIFO_DEPTH 4
`define RBT_APB_AW 8
`define RBT_OFS_CTRL 8'h00
`define RBT_OFS_STATUS 8'h04
`define RBT_OFS_FIFO 8'h08
`define RBT_OFS_SIG 8'h0C
`define RBT_CTRL_LOG_BIT 0
`define RBT_CTRL_RESET 32'h0000_0001
`define RBT_FIFO_VALID_BIT 8
`define RBT_STAT_TEST_BIT 16
`define RBT_STAT_DROP_BIT 17
`define RBT_STAT_TAP_LSB 20
`define RBT_IR_W 8
`define RBT_IR_BYPASS 8'hFF
`define RBT_IR_SAMPLE 8'h82
`define RBT_IR_EXTEST 8'h00
`define RBT_IR_PSA 8'h8A
`define RBT_IR_OUTPUT_PATTERN_GENERATION 8'h8B
`define RBT_BSR_W 18
`define RBT_SIG_W 16
`define RBT_SIG_RESET 16'h0001
`define RBT_SIG_TAPS 16'hB400
`endif

// file: core/rbt_pkg.sv
/*
 * Types of the registered bus transceiver.
 * Assumes rbt_cfg.svh is on the include path.
 */
`include "rbt_cfg.svh"
package rbt_pkg;
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010,
		TAP_CAP_DR = 4'b0011, TAP_SH_DR = 4'b0100, TAP_EX1_DR = 4'b0101,
		TAP_PAU_DR = 4'b0110, TAP_EX2_DR = 4'b0111, TAP_UPD_DR = 4'b1000,
		TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SH_IR = 4'b1011,
		TAP_EX1_IR = 4'b1100, TAP_PAU_IR = 4'b1101, TAP_EX2_IR = 4'b1110,
		TAP_UPD_IR = 4'b1111
	} rbt_tap_t;
endpackage

// file: core/rbt_top.sv
/*
 * Octal registered bus transceiver with scan test port, capture FIFO
 * and APB register slave; the FIFO module sits first in this file.
 * Assumes transceiver and scan pins asynchronous and APB pins synchronous to REF_CLK_I (100 MHz) and that the
 * bench resolves each bus wire from the _O and _OE_O pairs.
 */
// Local design decisions: the APB slave port and the placing of the registers.
// Notes on behaviour
// - A rising A-to-B capture clock loads the A pins into the A store.
// - With the A-to-B select low, live A data goes to the B outputs.
// - With the A-to-B select high, the A store goes to the B outputs.
// - B pins are driven only while the B output enable is high.
// - B-to-A works the same way with its own clock and select.
// - A pins are driven while the active-low A enable is low.
// - Each store captures on every rising edge of its own clock whatever the enables.
// - B driven from A with both clocks rising loads A data in both.
// - A driven from B with both clocks rising loads B data in both.
// - Both selects high and both enables on drive both stores out.
// - Test mode hands every pin to the boundary-scan logic; the code hands over only the bus drivers and their enables.
// - Scan use in normal mode leaves the transceiver undisturbed.
// - Scan offers input signature compression and output patterns.
// - The test logic is run only by its four dedicated pins.
// - Test logic samples on test clock rise; TDO changes on its fall, scan-driven bus pins after the rise.
`timescale 1ns/100ps
`include "rbt_cfg.svh"
module rbt_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	assign in_ready_o = (count != (AW+1)'(D));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		return (p == (AW)'(D - 1)) ? '0 : p + 1'b1;
	endfunction
	always_ff @(posedge clk_i)
		if (push)
			mem[wr_ptr] <= in_data_i;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= inc(wr_ptr);
			if (pop)
				rd_ptr <= inc(rd_ptr);
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule

`timescale 1ns/100ps
module rbt_top
	import rbt_pkg::*;
#(
	parameter int BUS_W = `RBT_BUS_W,
	parameter int FIFO_DEPTH = `RBT_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// Transceiver controls
	input wire logic A_TO_B_CAPTURE_CLOCK_I,
	input wire logic B_TO_A_CAPTURE_CLOCK_I,
	input wire logic A_TO_B_SOURCE_SELECT_I,
	input wire logic B_TO_A_SOURCE_SELECT_I,
	input wire logic B_SIDE_OUTPUT_ENABLE_I,
	input wire logic A_SIDE_OUTPUT_ENABLE_N_I,
	// A bus
	input wire logic [BUS_W-1:0] A_SIDE_BUS_I,
	output logic [BUS_W-1:0] A_SIDE_BUS_O,
	output logic A_SIDE_BUS_OE_O,
	// B bus
	input wire logic [BUS_W-1:0] B_SIDE_BUS_I,
	output logic [BUS_W-1:0] B_SIDE_BUS_O,
	output logic B_SIDE_BUS_OE_O,
	// Scan port
	input wire logic TEST_CLOCK_I,
	input wire logic TEST_MODE_SELECT_I,
	input wire logic TEST_DATA_I,
	output logic TEST_DATA_O,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [`RBT_APB_AW-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O
);
	localparam int SW = 2 * BUS_W + 9;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [2:0] prev_clk;
	logic [BUS_W-1:0] a_store;
	logic [BUS_W-1:0] b_store;
	rbt_tap_t tap;
	logic [`RBT_IR_W-1:0] ir_sh;
	logic [`RBT_IR_W-1:0] ir;
	logic [`RBT_BSR_W-1:0] bsr_sh;
	logic [`RBT_BSR_W-1:0] bsr_upd;
	logic [`RBT_SIG_W-1:0] sig;
	logic bypass_bit;
	logic [31:0] ctrl;
	logic drop;
	logic rd_fifo_ok;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [2*BUS_W-1:0] fifo_out_data;
	logic apb_fifo_pop;

	// Pins pass two flops; only sync2 is read
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			sync1 <= '0;
			sync2 <= '0;
			prev_clk <= '0;
		end
		else
		begin
			sync1 <= {TEST_CLOCK_I, TEST_MODE_SELECT_I, TEST_DATA_I,
				A_TO_B_CAPTURE_CLOCK_I, B_TO_A_CAPTURE_CLOCK_I,
				A_TO_B_SOURCE_SELECT_I, B_TO_A_SOURCE_SELECT_I,
				B_SIDE_OUTPUT_ENABLE_I, A_SIDE_OUTPUT_ENABLE_N_I,
				B_SIDE_BUS_I, A_SIDE_BUS_I};
			sync2 <= sync1;
			prev_clk <= {sync2[SW-1], sync2[SW-4], sync2[SW-5]};
		end

	wire [BUS_W-1:0] a_pin = sync2[BUS_W-1:0];
	wire [BUS_W-1:0] b_pin = sync2[2*BUS_W-1:BUS_W];
	wire a_side_output_enable_n_n = sync2[2*BUS_W];
	wire b_side_output_enable = sync2[2*BUS_W+1];
	wire b_to_a_source_select = sync2[2*BUS_W+2];
	wire a_to_b_source_select = sync2[2*BUS_W+3];
	wire ba_rise = sync2[2*BUS_W+4] && !prev_clk[0];
	wire ab_rise = sync2[2*BUS_W+5] && !prev_clk[1];
	wire tdi = sync2[SW-3];
	wire tms = sync2[SW-2];
	wire tck_rise = sync2[SW-1] && !prev_clk[2];
	wire tck_fall = !sync2[SW-1] && prev_clk[2];

	// Normal-mode selection
	wire [BUS_W-1:0] b_drive = a_to_b_source_select ? a_store : a_pin;
	wire [BUS_W-1:0] a_drive = b_to_a_source_select ? b_store : b_pin;
	wire a_oe_norm = !a_side_output_enable_n_n;
	// Driven pins read back what is driven so both stores see one value
	wire [BUS_W-1:0] a_cap = a_oe_norm ? a_drive : a_pin;
	wire [BUS_W-1:0] b_cap = b_side_output_enable ? b_drive : b_pin;

	// Each store loads on every rising edge of its own clock regardless of enables
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			a_store <= '0;
			b_store <= '0;
		end
		else
		begin
			if (ab_rise)
				a_store <= a_cap;
			if (ba_rise)
				b_store <= b_cap;
		end

	// Scan test port
	function automatic rbt_tap_t tap_next(input rbt_tap_t s, input logic m);
		case (s)
			TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: return m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: return m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: return m ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: return m ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: return m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: return m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: return m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: return m ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: return m ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: return m ? TAP_UPD_IR : TAP_SH_IR;
			default: return m ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction

	function automatic logic [`RBT_SIG_W-1:0] lfsr(
		input logic [`RBT_SIG_W-1:0] v);
		return (v >> 1) ^ (v[0] ? `RBT_SIG_TAPS : '0);
	endfunction

	wire sel_bsr = (ir == `RBT_IR_SAMPLE) || (ir == `RBT_IR_EXTEST);
	wire sel_sig = (ir == `RBT_IR_PSA) || (ir == `RBT_IR_OUTPUT_PATTERN_GENERATION);
	wire test_mode = (ir == `RBT_IR_EXTEST) || (ir == `RBT_IR_OUTPUT_PATTERN_GENERATION);
	wire run_idle = (tap == TAP_IDLE);
	wire [`RBT_SIG_W-1:0] psa_in = {b_pin, a_pin};
	wire tdo_next = (tap == TAP_SH_IR) ? ir_sh[0] :
		sel_bsr ? bsr_sh[0] : sel_sig ? sig[0] : bypass_bit;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			tap <= TAP_RESET;
			ir <= `RBT_IR_BYPASS;
			ir_sh <= '0;
			bsr_sh <= '0;
			bsr_upd <= '0;
			sig <= `RBT_SIG_RESET;
			bypass_bit <= 1'b0;
		end
		else if (tck_rise)
		begin
			tap <= tap_next(tap, tms);
			case (tap)
				TAP_RESET: ir <= `RBT_IR_BYPASS;
				TAP_CAP_IR: ir_sh <= 8'h01;
				TAP_SH_IR: ir_sh <= {tdi, ir_sh[`RBT_IR_W-1:1]};
				TAP_UPD_IR: ir <= ir_sh;
				TAP_CAP_DR:
				begin
					bsr_sh <= {a_side_output_enable_n_n, b_side_output_enable, b_pin, a_pin};
					bypass_bit <= 1'b0;
				end
				TAP_SH_DR:
				begin
					bsr_sh <= {tdi, bsr_sh[`RBT_BSR_W-1:1]};
					bypass_bit <= tdi;
					if (sel_sig)
						sig <= {tdi, sig[`RBT_SIG_W-1:1]};
				end
				TAP_UPD_DR: if (sel_bsr) bsr_upd <= bsr_sh;
				TAP_IDLE:
					if (ir == `RBT_IR_PSA)
						sig <= lfsr(sig) ^ psa_in;
					else if (ir == `RBT_IR_OUTPUT_PATTERN_GENERATION)
						sig <= lfsr(sig);
				default: ;
			endcase
		end

	// Serial output moves on the falling test clock
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
			TEST_DATA_O <= 1'b0;
		else if (tck_fall)
			TEST_DATA_O <= tdo_next;

	// Pin drivers: scan owns them in test mode
	wire [BUS_W-1:0] scan_a = (ir == `RBT_IR_OUTPUT_PATTERN_GENERATION) ? sig[BUS_W-1:0] :
		bsr_upd[BUS_W-1:0];
	wire [BUS_W-1:0] scan_b = (ir == `RBT_IR_OUTPUT_PATTERN_GENERATION) ?
		sig[2*BUS_W-1:BUS_W] : bsr_upd[2*BUS_W-1:BUS_W];
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			A_SIDE_BUS_O <= '0;
			B_SIDE_BUS_O <= '0;
			A_SIDE_BUS_OE_O <= 1'b0;
			B_SIDE_BUS_OE_O <= 1'b0;
		end
		else
		begin
			A_SIDE_BUS_O <= test_mode ? scan_a : a_drive;
			B_SIDE_BUS_O <= test_mode ? scan_b : b_drive;
			A_SIDE_BUS_OE_O <= test_mode ? !bsr_upd[`RBT_BSR_W-1] :
				a_oe_norm;
			B_SIDE_BUS_OE_O <= test_mode ? bsr_upd[`RBT_BSR_W-2] :
				b_side_output_enable;
		end

	// Capture log: each A-to-B capture while the FIFO has room queues both store images
	rbt_fifo #(.W(2 * BUS_W), .D(FIFO_DEPTH)) u_fifo (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.in_valid_i(ab_rise && ctrl[`RBT_CTRL_LOG_BIT]),
		.in_ready_o(fifo_in_ready),
		.in_data_i({b_store, a_cap}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(apb_fifo_pop),
		.out_data_o(fifo_out_data)
	);

	// APB slave, zero wait states, read data sampled in setup
	wire apb_setup = PSEL_I && !PENABLE_I;
	wire apb_done = PSEL_I && PENABLE_I;
	wire hit_ctrl = (PADDR_I == `RBT_OFS_CTRL);
	wire hit_stat = (PADDR_I == `RBT_OFS_STATUS);
	wire hit_fifo = (PADDR_I == `RBT_OFS_FIFO);
	wire hit_sig = (PADDR_I == `RBT_OFS_SIG);
	wire hit_any = hit_ctrl || hit_stat || hit_fifo || hit_sig;
	assign apb_fifo_pop = apb_done && !PWRITE_I && hit_fifo && rd_fifo_ok;
	wire [31:0] stat_word = {8'h00, tap, 2'b00, drop, test_mode,
		b_store, a_store};
	wire [31:0] fifo_word = {15'h0000, fifo_out_valid, fifo_out_data};
	wire [31:0] rd_word = hit_ctrl ? ctrl : hit_stat ? stat_word :
		hit_fifo ? fifo_word : hit_sig ? {16'h0000, sig} : 32'h0000_0000;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = apb_done && !hit_any;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
		if (!RST_N_I)
		begin
			ctrl <= `RBT_CTRL_RESET;
			PRDATA_O <= '0;
			rd_fifo_ok <= 1'b0;
			drop <= 1'b0;
		end
		else
		begin
			if (apb_setup)
			begin
				PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_word;
				rd_fifo_ok <= fifo_out_valid;
			end
			if (apb_done && PWRITE_I && hit_ctrl)
				ctrl <= PWDATA_I;
			if (ab_rise && ctrl[`RBT_CTRL_LOG_BIT] && !fifo_in_ready)
				drop <= 1'b1;
			else if (apb_done && PWRITE_I && hit_stat &&
				PWDATA_I[`RBT_STAT_DROP_BIT])
				drop <= 1'b0;
		end

	// Checks
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	property p_ab_load;
		ab_rise && a_side_output_enable_n_n |=> a_store == $past(a_pin);
	endproperty
	a_ab_load: assert property (p_ab_load) else $error("A store missed");
	property p_transp;
		!test_mode && !a_to_b_source_select |=> B_SIDE_BUS_O == $past(a_pin);
	endproperty
	a_transp: assert property (p_transp) else $error("B not live");
	property p_stored;
		!test_mode && a_to_b_source_select && !ab_rise ##1 !ab_rise |-> B_SIDE_BUS_O == a_store;
	endproperty
	a_stored: assert property (p_stored) else $error("B not stored");
	property p_b_oe;
		!test_mode |=> B_SIDE_BUS_OE_O == $past(b_side_output_enable);
	endproperty
	a_b_oe: assert property (p_b_oe) else $error("B enable wrong");
	property p_ba_load;
		ba_rise && !b_side_output_enable |=> b_store == $past(b_pin);
	endproperty
	a_ba_load: assert property (p_ba_load) else $error("B store missed");
	property p_a_oe;
		!test_mode |=> A_SIDE_BUS_OE_O == !$past(a_side_output_enable_n_n);
	endproperty
	a_a_oe: assert property (p_a_oe) else $error("A enable wrong");
	property p_both_ab;
		ab_rise && ba_rise && b_side_output_enable && a_side_output_enable_n_n && !a_to_b_source_select |=> a_store == b_store;
	endproperty
	a_both_ab: assert property (p_both_ab) else $error("Stores differ");
	property p_both_ba;
		ab_rise && ba_rise && a_oe_norm && !b_side_output_enable && !b_to_a_source_select |=> a_store == b_store;
	endproperty
	a_both_ba: assert property (p_both_ba) else $error("Stores differ");
	property p_scan_oe;
		test_mode ##1 test_mode |-> B_SIDE_BUS_OE_O == $past(bsr_upd[16]);
	endproperty
	a_scan_oe: assert property (p_scan_oe) else $error("Scan enable");
	property p_tdo_fall;
		$changed(TEST_DATA_O) |-> $past(tck_fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("TDO edge");
endmodule

// file: sim/rbt_bus_partner.sv
/*
 * Board logic on the two octal buses: drives each bus when asked and
 * resolves every wire from both parties' enables.
 * Assumes the device reports drive value and enable per side.
 */
`timescale 1ns/100ps
module rbt_bus_partner (
	// Clock
	input wire logic clk_i,
	// Far-side drive
	input wire logic [7:0] a_far_i,
	input wire logic a_far_en_i,
	input wire logic [7:0] b_far_i,
	input wire logic b_far_en_i,
	// Device drive
	input wire logic [7:0] a_dev_i,
	input wire logic a_dev_oe_i,
	input wire logic [7:0] b_dev_i,
	input wire logic b_dev_oe_i,
	// Resolved wires
	output logic [7:0] a_wire_o,
	output logic [7:0] b_wire_o
);
	logic [7:0] a_last = 8'h00;
	logic [7:0] b_last = 8'h00;
	// Floating or contended wires show a pattern that flips every cycle
	always_ff @(posedge clk_i)
	begin
		a_last <= a_wire_o;
		b_last <= b_wire_o;
	end
	assign a_wire_o = (a_dev_oe_i && !a_far_en_i) ? a_dev_i :
		(a_far_en_i && !a_dev_oe_i) ? a_far_i : ~a_last;
	assign b_wire_o = (b_dev_oe_i && !b_far_en_i) ? b_dev_i :
		(b_far_en_i && !b_dev_oe_i) ? b_far_i : ~b_last;
endmodule

// file: sim/rbt_tb.sv
/*
 * Self-checking bench of the registered bus transceiver.
 * Assumes rbt_top, rbt_bus_partner and rbt_cfg.svh are available.
 */
`timescale 1ns/100ps
`include "rbt_cfg.svh"
module registered_bidir_octal_transceiver_tb;
	logic clk, rst_n, cab, cba, a_to_b_source_select, b_to_a_source_select, b_side_output_enable, a_side_output_enable_n_n;
	logic [7:0] a_far, b_far, a_wire, b_wire, a_o, b_o, paddr;
	logic a_far_en, b_far_en, a_oe, b_oe, psel, pen, pwr, prdy, perr, er;
	logic [31:0] pwd, prd, rd;
	logic tck, tms, tdi, tdo;
	int mismatches = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	rbt_bus_partner u_far (.clk_i(clk), .a_far_i(a_far),
		.a_far_en_i(a_far_en), .b_far_i(b_far), .b_far_en_i(b_far_en),
		.a_dev_i(a_o), .a_dev_oe_i(a_oe), .b_dev_i(b_o),
		.b_dev_oe_i(b_oe), .a_wire_o(a_wire), .b_wire_o(b_wire));
	rbt_top DUT (.REF_CLK_I(clk), .RST_N_I(rst_n),
		.A_TO_B_CAPTURE_CLOCK_I(cab), .B_TO_A_CAPTURE_CLOCK_I(cba),
		.A_TO_B_SOURCE_SELECT_I(a_to_b_source_select), .B_TO_A_SOURCE_SELECT_I(b_to_a_source_select),
		.B_SIDE_OUTPUT_ENABLE_I(b_side_output_enable), .A_SIDE_OUTPUT_ENABLE_N_I(a_side_output_enable_n_n),
		.A_SIDE_BUS_I(a_wire), .A_SIDE_BUS_O(a_o), .A_SIDE_BUS_OE_O(a_oe),
		.B_SIDE_BUS_I(b_wire), .B_SIDE_BUS_O(b_o), .B_SIDE_BUS_OE_O(b_oe),
		.TEST_CLOCK_I(tck), .TEST_MODE_SELECT_I(tms),
		.TEST_DATA_I(tdi), .TEST_DATA_O(tdo), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
		.PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr));
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= ad;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Controls and far-side drive, then time for the pins to settle
	task automatic setc(input logic s1, s2, o1, o2, e1, e2,
		input logic [7:0] av, bv);
		@(posedge clk);
		a_to_b_source_select <= s1;
		b_to_a_source_select <= s2;
		b_side_output_enable <= o1;
		a_side_output_enable_n_n <= o2;
		a_far_en <= e1;
		b_far_en <= e2;
		a_far <= av;
		b_far <= bv;
		wt(6);
	endtask
	task automatic pulse(input logic a, b);
		@(posedge clk);
		cab <= a;
		cba <= b;
		wt(4);
		cab <= 1'b0;
		cba <= 1'b0;
		wt(4);
	endtask
	task automatic t_a_to_b;
		setc(0, 0, 1, 1, 1, 0, 8'h5A, 8'h00);
		chk("b_oe", b_oe, 1);
		chk("b_live", b_o, 8'h5A);
		chk("a_oe", a_oe, 0);
		setc(1, 0, 1, 1, 1, 0, 8'h96, 8'h00);
		pulse(1, 0);
		setc(1, 0, 1, 1, 1, 0, 8'h0F, 8'h00);
		chk("b_stored", b_o, 8'h96);
		setc(0, 0, 1, 1, 1, 0, 8'h0F, 8'h00);
		chk("b_live2", b_o, 8'h0F);
		setc(0, 0, 0, 1, 1, 1, 8'h0F, 8'hC3);
		chk("b_off", b_oe, 0);
	endtask
	task automatic t_b_to_a;
		setc(0, 1, 0, 0, 0, 1, 8'h00, 8'h42);
		pulse(0, 1);
		setc(0, 1, 0, 0, 0, 1, 8'h00, 8'h24);
		chk("a_on", a_oe, 1);
		chk("a_stored", a_o, 8'h42);
		setc(0, 0, 0, 0, 0, 1, 8'h00, 8'h24);
		chk("a_live", a_o, 8'h24);
		setc(0, 0, 0, 1, 0, 1, 8'h00, 8'h24);
		chk("a_off", a_oe, 0);
	endtask
	task automatic t_stores;
		setc(0, 0, 0, 1, 1, 1, 8'h3C, 8'hA5);
		pulse(1, 1);
		apb(0, `RBT_OFS_STATUS, 0);
		chk("isolated", rd[15:0], 16'hA53C);
		setc(1, 1, 1, 0, 0, 0, 8'h00, 8'h00);
		chk("both_b", b_o, 8'h3C);
		chk("both_a", a_o, 8'hA5);
		chk("both_oe", {a_oe, b_oe}, 2'b11);
		setc(0, 0, 1, 1, 1, 0, 8'h77, 8'h00);
		pulse(1, 1);
		apb(0, `RBT_OFS_STATUS, 0);
		chk("a_both", rd[15:0], 16'h7777);
		setc(0, 0, 0, 0, 0, 1, 8'h00, 8'hE1);
		pulse(1, 1);
		apb(0, `RBT_OFS_STATUS, 0);
		chk("b_both", rd[15:0], 16'hE1E1);
		setc(1, 0, 1, 1, 1, 0, 8'h6D, 8'h00);
		pulse(1, 0);
		pulse(0, 1);
		apb(0, `RBT_OFS_STATUS, 0);
		chk("staggered", rd[15:0], 16'h6D6D);
	endtask
	task automatic t_fifo;
		apb(0, `RBT_OFS_CTRL, 0);
		chk("ctrl_rst", rd, `RBT_CTRL_RESET);
		apb(0, 8'h10, 0);
		chk("unmapped_err", er, 1);
		chk("unmapped_rd", rd, 0);
		repeat (8) apb(0, `RBT_OFS_FIFO, 0);
		apb(1, `RBT_OFS_STATUS, 32'h0002_0000);
		for (int i = 1; i <= 5; i++)
		begin
			setc(0, 0, 0, 1, 1, 1, 8'(i), 8'h00);
			pulse(1, 0);
		end
		apb(0, `RBT_OFS_STATUS, 0);
		chk("drop_set", rd[17], 1);
		for (int i = 1; i <= 4; i++)
		begin
			apb(0, `RBT_OFS_FIFO, 0);
			chk("fifo_head", {rd[16], rd[7:0]}, {1'b1, 8'(i)});
		end
		apb(0, `RBT_OFS_FIFO, 0);
		chk("fifo_empty", rd[16], 0);
		apb(1, `RBT_OFS_STATUS, 32'h0002_0000);
		apb(0, `RBT_OFS_STATUS, 0);
		chk("drop_clear", rd[17], 0);
	endtask
	// One test clock period; each level spans at least four clocks
	task automatic tstep(input logic m, d);
		@(posedge clk);
		tms <= m;
		tdi <= d;
		wt(4);
		tck <= 1'b1;
		wt(4);
		tck <= 1'b0;
	endtask
	// From Run-Test/Idle through an instruction scan back to idle
	task automatic ir_load(input logic [7:0] op);
		tstep(1, 0);
		tstep(1, 0);
		tstep(0, 0);
		tstep(0, 0);
		wt(4);
		chk("tdo_cap", tdo, 1);
		for (int i = 0; i < 8; i++)
		begin
			tstep(i == 7, op[i]);
			if (i == 0)
			begin
				wt(4);
				chk("tdo_shift", tdo, 0);
			end
		end
		tstep(1, 0);
		tstep(0, 0);
		wt(2);
	endtask
	task automatic t_scan;
		tstep(0, 0);
		ir_load(`RBT_IR_SAMPLE);
		setc(0, 0, 1, 1, 1, 0, 8'h5A, 8'h00);
		chk("sample_live", b_o, 8'h5A);
		ir_load(`RBT_IR_PSA);
		setc(0, 0, 0, 1, 1, 1, 8'h3C, 8'hA5);
		tstep(0, 0);
		apb(0, `RBT_OFS_SIG, 0);
		chk("psa_step", rd, 32'h0000_113C);
		setc(0, 0, 1, 0, 0, 0, 8'h00, 8'h00);
		ir_load(`RBT_IR_EXTEST);
		chk("ext_oe", {a_oe, b_oe}, 2'b10);
		chk("ext_a", a_o, 8'h00);
		apb(0, `RBT_OFS_STATUS, 0);
		chk("ext_flag", rd[16], 1);
		repeat (4) tstep(1, 0);
		wt(2);
		chk("scan_off", {a_oe, b_oe}, 2'b11);
	endtask
	task automatic results;
		$display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#200000;
		mismatches++;
		results();
	end
	initial
	begin
		clk = 0;
		rst_n = 0;
		{cab, cba, a_to_b_source_select, b_to_a_source_select, b_side_output_enable, psel, pen, pwr} = '0;
		{a_far_en, b_far_en, a_side_output_enable_n_n} = 3'b001;
		{a_far, b_far, paddr, pwd} = '0;
		{tck, tms, tdi} = 3'b011;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_a_to_b();
		t_b_to_a();
		t_stores();
		t_fifo();
		t_scan();
		results();
	end
endmodule
